// file: verilog/rms_sequencer.v
`timescale 1ns/100ps
`include "rms_defs.vh"

// Functional notes
// R1: Only one rod selected; new selection accepted only while idle.
// R2: Other selections ignored from motion start until cycle fully completes.
// R3: Selection never cleared mid-cycle; only reset clears it then.
// R4: Insert bus with selection opens both insert valves of that rod only.
// R5: Withdraw and settle buses with selection open both withdraw valves.
// R6: Settle alone opens only the settle-tied withdraw valve of the rod.
// R7: Momentary rod-in starts a timed insert bus interval.
// R8: Settle bus rises before insert drops and lingers a limited time.
// R9: Insert interval sized for one notch per momentary rod-in.
// R10: Holding rod-in keeps the insert bus energized continuously.
// R11: Holding emergency-in keeps the insert bus energized continuously.
// R12: Rod-out-notch starts with a brief unlatch insert pulse.
// R13: After unlatch pulse, withdraw and settle buses energize together.
// R14: Withdraw bus drops before settle; settle drop ends the cycle.
// R15: Withdraw cycle identical whether switch is held or released.
// R16: Withdraw intervals sized for one notch per cycle.
// R17: Timer failure blocks further motion and drops all buses.
// R18: Rod-out-notch plus notch-override held keeps withdraw bus on.
// R19: Withdraw block stops the rod at the next notch position.
// R20: All intervals are parameters counted in clock cycles.
module rms_sequencer #(
    parameter N_RODS = 8,
    parameter SEL_W = 3,
    parameter INS_NOTCH_CYC = `RMS_INS_NOTCH_CYC, // R20
    parameter INS_LEAD_CYC = `RMS_INS_SETTLE_LEAD_CYC,
    parameter SETTLE_AFTER_CYC = `RMS_SETTLE_AFTER_CYC,
    parameter UNLATCH_CYC = `RMS_UNLATCH_CYC,
    parameter WD_CYC = `RMS_WD_CYC,
    parameter WD_SETTLE_CYC = `RMS_WD_SETTLE_CYC,
    parameter WDOG_CYC = `RMS_WDOG_CYC
) (
    input wire core_clk,
    input wire arst_n,
    input wire select_req,
    input wire [SEL_W-1:0] select_rod,
    input wire rod_in_sw,
    input wire rod_out_notch_sw,
    input wire emergency_in_sw,
    input wire notch_override_sw,
    input wire withdraw_block,
    output reg insert_bus,
    output reg withdraw_bus,
    output reg settle_bus,
    output reg rod_selected,
    output reg [SEL_W-1:0] selected_rod,
    output reg cycle_busy,
    output reg timer_fault,
    output reg [N_RODS-1:0] insert_valve_a,
    output reg [N_RODS-1:0] insert_valve_b,
    output reg [N_RODS-1:0] withdraw_valve,
    output reg [N_RODS-1:0] settle_valve
);

// ==========================================================
// States
localparam [6:0] S_IDLE = 7'h01;
localparam [6:0] S_INS = 7'h02;
localparam [6:0] S_INS_SET = 7'h04;
localparam [6:0] S_UNLATCH = 7'h08;
localparam [6:0] S_WD = 7'h10;
localparam [6:0] S_WD_SET = 7'h20;
localparam [6:0] S_FAULT = 7'h40;

reg [6:0] state;
reg [6:0] next_state;
reg [31:0] tmr;
reg [31:0] next_tmr;
reg [31:0] wdog;
reg held;
reg next_held;
reg [N_RODS-1:0] onehot;
reg out_armed;

function [N_RODS-1:0] rod_decode;
    input [SEL_W-1:0] idx;
    integer i;
    begin
        for (i = 0; i < N_RODS; i = i + 1)
            rod_decode[i] = (idx == i[SEL_W-1:0]);
    end
endfunction

// Last count of the interval timer in each timed phase
// Zero for untimed states; overrun skips S_IDLE and S_FAULT, so no count there trips it
function [31:0] phase_end;
    input [6:0] st;
    begin
        case (st)
            S_INS:
                phase_end = INS_NOTCH_CYC - INS_LEAD_CYC - 1;
            S_INS_SET:
                phase_end = INS_LEAD_CYC + SETTLE_AFTER_CYC - 1;
            S_UNLATCH:
                phase_end = UNLATCH_CYC - 1;
            S_WD:
                phase_end = WD_CYC - 1;
            S_WD_SET:
                phase_end = WD_SETTLE_CYC - 1;
            default:
                phase_end = 32'h0000_0000;
        endcase
    end
endfunction

wire idle = (state == S_IDLE);
wire go_in = rod_selected && (rod_in_sw || emergency_in_sw);
wire go_out = rod_selected && rod_out_notch_sw && !withdraw_block && out_armed;
// A timer counting past its phase end has failed; motion stops for good
wire overrun = (state != S_IDLE) && (state != S_FAULT) && (tmr > phase_end(state));
wire cont_wd = rod_out_notch_sw && notch_override_sw && !withdraw_block;
wire cont_in = rod_in_sw || emergency_in_sw;

// ==========================================================
// Sequencer
always @*
begin
    next_state = state;
    next_tmr = tmr;
    next_held = held;
    case (state)
        S_IDLE:
        begin
            next_tmr = 32'h0000_0000;
            if (go_in)
            begin
                next_state = S_INS; // R7
                next_held = 1'b1;
            end
            else if (go_out)
                next_state = S_UNLATCH; // R12
        end
        S_INS:
        begin
            if (!cont_in)
                next_held = 1'b0;
            else if (emergency_in_sw)
                next_held = 1'b1; // R11
            if (held && cont_in)
                next_tmr = 32'h0000_0000; // R10 R11
            else if (tmr >= phase_end(state)) // R9
            begin
                next_state = S_INS_SET; // R8
                next_tmr = 32'h0000_0000;
            end
            else
                next_tmr = tmr + 32'h0000_0001;
        end
        S_INS_SET:
        begin
            // Emergency-in during settle goes straight back to inserting
            if (emergency_in_sw)
            begin
                next_state = S_INS; // R11
                next_tmr = 32'h0000_0000;
                next_held = 1'b1;
            end
            else if (tmr >= phase_end(state)) // R8
            begin
                next_state = S_IDLE;
                next_tmr = 32'h0000_0000;
            end
            else
                next_tmr = tmr + 32'h0000_0001;
        end
        S_UNLATCH:
        begin
            if (tmr >= phase_end(state)) // R12 R13
            begin
                next_state = S_WD;
                next_tmr = 32'h0000_0000;
            end
            else
                next_tmr = tmr + 32'h0000_0001;
        end
        S_WD:
        begin
            // Switch release matters only with notch override held, so held and released match without it
            if (cont_wd && tmr >= phase_end(state))
                next_tmr = 32'h0000_0000; // R18 R15
            else if (tmr >= phase_end(state)) // R16 R19
            begin
                next_state = S_WD_SET; // R14
                next_tmr = 32'h0000_0000;
            end
            else
                next_tmr = tmr + 32'h0000_0001;
        end
        S_WD_SET:
        begin
            if (tmr >= phase_end(state)) // R14
            begin
                next_state = S_IDLE;
                next_tmr = 32'h0000_0000;
            end
            else
                next_tmr = tmr + 32'h0000_0001;
        end
        S_FAULT:
            next_state = S_FAULT; // R17
        default:
            next_state = S_FAULT;
    endcase
end

always @(posedge core_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        state <= S_IDLE;
        tmr <= 32'h0000_0000;
        held <= 1'b0;
        wdog <= 32'h0000_0000;
    end
    else
    begin
        // Watchdog: a bus held past its bound with no timer progress is a fault
        if (state != S_IDLE && next_tmr == tmr && state != S_FAULT && !held && !cont_wd)
            wdog <= wdog + 32'h0000_0001;
        else
            wdog <= 32'h0000_0000;
        if (wdog >= WDOG_CYC || overrun)
            state <= S_FAULT; // R17
        else
            state <= next_state;
        tmr <= next_tmr;
        held <= next_held;
    end
end

// ==========================================================
// Selection interlock
always @(posedge core_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        rod_selected <= 1'b0;
        selected_rod <= {SEL_W{1'b0}};
    end
    else if (select_req && idle && !go_in && !go_out && select_rod < N_RODS) // R1 R2 R3
    begin
        rod_selected <= 1'b1;
        selected_rod <= select_rod;
    end
end

// ==========================================================
// Rod-out re-arm: a held switch gives one withdraw cycle, never a second cycle
// Cleared by reset, so a switch stuck high at power-up moves nothing
always @(posedge core_clk or negedge arst_n)
begin
    if (!arst_n)
        out_armed <= 1'b0;
    else if (!rod_out_notch_sw)
        out_armed <= 1'b1; // R15
    else if (idle && go_out)
        out_armed <= 1'b0; // R15
end

// ==========================================================
// Buses and valves, registered
always @*
begin
    onehot = rod_selected ? rod_decode(selected_rod) : {N_RODS{1'b0}};
end

wire nx_ins = (next_state == S_INS) || (next_state == S_UNLATCH)
    || ((next_state == S_INS_SET) && (next_tmr < INS_LEAD_CYC));
wire nx_wd = (next_state == S_WD);
wire nx_set = (next_state == S_INS_SET) || (next_state == S_WD) || (next_state == S_WD_SET);

always @(posedge core_clk or negedge arst_n)
begin
    if (!arst_n)
    begin
        insert_bus <= 1'b0;
        withdraw_bus <= 1'b0;
        settle_bus <= 1'b0;
        cycle_busy <= 1'b0;
        timer_fault <= 1'b0;
        insert_valve_a <= {N_RODS{1'b0}};
        insert_valve_b <= {N_RODS{1'b0}};
        withdraw_valve <= {N_RODS{1'b0}};
        settle_valve <= {N_RODS{1'b0}};
    end
    else
    begin
        insert_bus <= nx_ins && !timer_fault; // R17
        withdraw_bus <= nx_wd && !timer_fault;
        settle_bus <= nx_set && !timer_fault;
        cycle_busy <= (next_state != S_IDLE);
        timer_fault <= timer_fault || (state == S_FAULT);
        insert_valve_a <= (nx_ins && !timer_fault) ? onehot : {N_RODS{1'b0}}; // R4
        insert_valve_b <= (nx_ins && !timer_fault) ? onehot : {N_RODS{1'b0}}; // R4
        withdraw_valve <= (nx_wd && nx_set && !timer_fault) ? onehot : {N_RODS{1'b0}}; // R5
        settle_valve <= (nx_set && !timer_fault) ? onehot : {N_RODS{1'b0}}; // R5 R6
    end
end

endmodule

// file: verilog/rms_defs.vh
`ifndef RMS_DEFS_VH
`define RMS_DEFS_VH

// Interval durations in core_clk cycles (25 MHz)
`define RMS_INS_NOTCH_CYC 32'h0000_0064
`define RMS_INS_SETTLE_LEAD_CYC 32'h0000_000A
`define RMS_SETTLE_AFTER_CYC 32'h0000_0032
`define RMS_UNLATCH_CYC 32'h0000_0014
`define RMS_WD_CYC 32'h0000_0050
`define RMS_WD_SETTLE_CYC 32'h0000_0064
`define RMS_WDOG_CYC 32'h0000_1000

`endif

// file: test/rms_properties.sv
`timescale 1ns/100ps
module rms_properties #(
    parameter N_RODS = 8,
    parameter SEL_W = 3
) (
    input wire core_clk,
    input wire arst_n,
    input wire insert_bus,
    input wire withdraw_bus,
    input wire settle_bus,
    input wire rod_selected,
    input wire [SEL_W-1:0] selected_rod,
    input wire cycle_busy,
    input wire timer_fault,
    input wire [N_RODS-1:0] insert_valve_a,
    input wire [N_RODS-1:0] insert_valve_b,
    input wire [N_RODS-1:0] withdraw_valve
);
    wire [N_RODS-1:0] hot = {{(N_RODS-1){1'b0}}, 1'b1} << selected_rod;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    a_sel_held: assert property (cycle_busy && $past(cycle_busy) |-> $stable(selected_rod))
        else $error("selection moved");
    a_sel_kept: assert property (cycle_busy |-> rod_selected)
        else $error("selection lost");
    a_ins_valves: assert property (insert_bus && rod_selected |-> insert_valve_a == hot
        && insert_valve_b == hot) else $error("insert valves wrong");
    a_wd_valve: assert property (withdraw_bus && rod_selected |-> withdraw_valve == hot)
        else $error("withdraw valve wrong");
    a_settle_only: assert property (settle_bus && !insert_bus && !withdraw_bus
        |-> (insert_valve_a | insert_valve_b | withdraw_valve) == '0) else $error("settle valves");
    a_settle_lead: assert property ($fell(insert_bus) |-> settle_bus)
        else $error("settle not up at insert drop");
    a_wd_in_settle: assert property (withdraw_bus |-> settle_bus)
        else $error("withdraw without settle");
    a_no_overlap: assert property (!(insert_bus && withdraw_bus))
        else $error("insert and withdraw together");
    a_fault_dead: assert property (timer_fault |-> !insert_bus && !withdraw_bus)
        else $error("bus live after fault");
    c_insert: cover property ($fell(insert_bus) && !withdraw_bus);
    c_withdraw: cover property ($fell(withdraw_bus));
    c_busy_end: cover property ($fell(cycle_busy));
endmodule
bind rms_sequencer rms_properties #(.N_RODS(N_RODS), .SEL_W(SEL_W)) i_prop (
    .core_clk(core_clk), .arst_n(arst_n), .insert_bus(insert_bus),
    .withdraw_bus(withdraw_bus), .settle_bus(settle_bus), .rod_selected(rod_selected),
    .selected_rod(selected_rod), .cycle_busy(cycle_busy), .timer_fault(timer_fault),
    .insert_valve_a(insert_valve_a), .insert_valve_b(insert_valve_b),
    .withdraw_valve(withdraw_valve));

// file: test/rms_valve_model.sv
`timescale 1ns/100ps
// Valve bank: a rod moves when any of its solenoids is open
module rms_valve_model (
    input wire [7:0] insert_valve_a,
    input wire [7:0] insert_valve_b,
    input wire [7:0] withdraw_valve,
    input wire [7:0] settle_valve,
    output wire [7:0] open_rods
);
    assign open_rods = insert_valve_a | insert_valve_b | withdraw_valve | settle_valve;
endmodule

// file: test/tb.sv
`timescale 1ns/100ps
module tb;
    localparam INS = 8, LEAD = 2, AFT = 4, UNL = 3, WD = 6, WDS = 5;
    reg core_clk = 0, arst_n = 0, select_req = 0, withdraw_block = 0;
    reg rod_in_sw = 0, rod_out_notch_sw = 0, emergency_in_sw = 0, notch_override_sw = 0;
    reg [2:0] select_rod = 3'h0;
    wire insert_bus, withdraw_bus, settle_bus, rod_selected, cycle_busy, timer_fault;
    wire [2:0] selected_rod;
    wire [7:0] iva, ivb, wv, sv, open_rods;
    reg [7:0] exp_v;
    integer err_count = 0, compares = 0, cyc = 0, ni, nw, ns, bad, k, s;
    rms_sequencer #(.INS_NOTCH_CYC(INS), .INS_LEAD_CYC(LEAD), .SETTLE_AFTER_CYC(AFT),
        .UNLATCH_CYC(UNL), .WD_CYC(WD), .WD_SETTLE_CYC(WDS), .WDOG_CYC(64)) i_dut (
        .core_clk(core_clk), .arst_n(arst_n), .select_req(select_req),
        .select_rod(select_rod), .rod_in_sw(rod_in_sw), .rod_out_notch_sw(rod_out_notch_sw),
        .emergency_in_sw(emergency_in_sw), .notch_override_sw(notch_override_sw),
        .withdraw_block(withdraw_block), .insert_bus(insert_bus), .withdraw_bus(withdraw_bus),
        .settle_bus(settle_bus), .rod_selected(rod_selected), .selected_rod(selected_rod),
        .cycle_busy(cycle_busy), .timer_fault(timer_fault), .insert_valve_a(iva),
        .insert_valve_b(ivb), .withdraw_valve(wv), .settle_valve(sv));
    rms_valve_model i_valves (.insert_valve_a(iva), .insert_valve_b(ivb),
        .withdraw_valve(wv), .settle_valve(sv), .open_rods(open_rods));
    always #20 core_clk = ~core_clk;
    // Whole run needs well under a thousand cycles
    always @(posedge core_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 3000)
        begin
            err_count = err_count + 1;
            summarize;
        end
    end
    task summarize;
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task check(input string name, input [31:0] exp, input [31:0] got);
        compares = compares + 1;
        if (exp !== got)
        begin
            $display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
            err_count = err_count + 1;
        end
    endtask
    // Counts bus cycles from this falling edge on, until the block is idle
    task meas;
        ni = 0; nw = 0; ns = 0; bad = 0;
        for (k = 0; k < 300; k = k + 1)
        begin
            ni = ni + insert_bus;
            nw = nw + withdraw_bus;
            ns = ns + settle_bus;
            exp_v = 8'h01 << selected_rod;
            if (open_rods !== 8'h00 && open_rods !== exp_v)
                bad = bad + 1;
            if (iva !== (insert_bus ? exp_v : 8'h00) || ivb !== iva)
                bad = bad + 1;
            if (wv !== ((withdraw_bus && settle_bus) ? exp_v : 8'h00))
                bad = bad + 1;
            if (sv !== (settle_bus ? exp_v : 8'h00))
                bad = bad + 1;
            if (!cycle_busy)
                k = 300;
            else
                @(negedge core_clk);
        end
    endtask
    task sel(input [2:0] r);
        @(negedge core_clk);
        select_req = 1;
        select_rod = r;
        @(negedge core_clk);
        select_req = 0;
        check("selected_rod", r, selected_rod);
        check("rod_selected", 1, rod_selected);
    endtask
    task t_notch;
        sel(3'h5);
        @(negedge core_clk);
        select_rod = 3'h2;
        select_req = 1;
        rod_in_sw = 1;
        @(negedge core_clk);
        rod_in_sw = 0;
        meas;
        select_req = 0;
        check("notch insert", INS, ni);
        check("notch settle", LEAD + AFT, ns);
        check("notch withdraw", 0, nw);
        check("kept rod", 5, selected_rod);
        check("foreign valves", 0, bad);
        $display("test notch done");
    endtask
    task t_withdraw;
        for (s = 0; s < 2; s = s + 1)
        begin
            sel(3'h3);
            rod_out_notch_sw = 1;
            @(negedge core_clk);
            rod_out_notch_sw = s;
            meas;
            check("unlatch insert", UNL, ni);
            check("withdraw bus", WD, nw);
            check("withdraw settle", WD + WDS, ns);
            check("foreign valves", 0, bad);
            repeat (2) @(negedge core_clk);
            check("no repeat on hold", 0, cycle_busy);
            rod_out_notch_sw = 0;
        end
        $display("test withdraw done");
    endtask
    task t_held;
        for (s = 0; s < 2; s = s + 1)
        begin
            sel(3'h1);
            rod_in_sw = !s;
            emergency_in_sw = s;
            repeat (3 * INS) @(negedge core_clk);
            check("held insert", 1, insert_bus);
            rod_in_sw = 0;
            emergency_in_sw = 0;
            meas;
        end
        $display("test held done");
    endtask
    task t_cont_wd;
        sel(3'h6);
        rod_out_notch_sw = 1;
        notch_override_sw = 1;
        repeat (4 * WD) @(negedge core_clk);
        check("cont withdraw", 1, withdraw_bus);
        withdraw_block = 1;
        meas;
        check("stop at notch", WD - ((4 * WD - 1 - UNL) % WD), nw);
        rod_out_notch_sw = 0;
        notch_override_sw = 0;
        @(negedge core_clk);
        rod_out_notch_sw = 1;
        @(negedge core_clk);
        rod_out_notch_sw = 0;
        meas;
        check("blocked insert", 0, ni);
        check("timer fault", 0, timer_fault);
        withdraw_block = 0;
        $display("test cont_wd done");
    endtask
    initial
    begin
        repeat (8) @(negedge core_clk);
        arst_n = 1;
        t_notch;
        t_withdraw;
        t_held;
        t_cont_wd;
        summarize;
    end
endmodule
